// File: include/fcq_consts.svh
// Constants of the query-table reader: commands, table addresses, expected data and timing.
`ifndef FCQ_CONSTS_SVH
`define FCQ_CONSTS_SVH

`define FCQ_CMD_QUERY 8'h98
`define FCQ_CMD_RESET 8'hf0
`define FCQ_QADDR_WORD 20'h00055
`define FCQ_QADDR_BYTE 20'h000aa
`define FCQ_RST_ADDR 20'h00000

`define FCQ_IDX_FIRST 6'h10
`define FCQ_IDX_LAST 6'h3c
`define FCQ_IDX_ZERO 6'h00

`define FCQ_A_Q 6'h10
`define FCQ_A_R 6'h11
`define FCQ_A_Y 6'h12
`define FCQ_A_PRI_SET 6'h13
`define FCQ_A_PRI_TBL 6'h15
`define FCQ_A_VCC_MIN 6'h1b
`define FCQ_A_VCC_MAX 6'h1c
`define FCQ_A_TYP_WR 6'h1f
`define FCQ_A_TYP_BLK 6'h21
`define FCQ_A_MAX_WR 6'h23
`define FCQ_A_MAX_BLK 6'h25
`define FCQ_A_SIZE 6'h27
`define FCQ_A_IFACE 6'h28
`define FCQ_A_NREG 6'h2c
`define FCQ_A_R1_CNT 6'h2d
`define FCQ_A_R1_SZ 6'h2f
`define FCQ_A_R2_CNT 6'h31
`define FCQ_A_R2_SZH 6'h34

`define FCQ_D_Q 16'h0051
`define FCQ_D_R 16'h0052
`define FCQ_D_Y 16'h0059
`define FCQ_D_PRI_SET 16'h0002
`define FCQ_D_PRI_TBL 16'h0040
`define FCQ_D_VCC_MIN 16'h0017
`define FCQ_D_VCC_MAX 16'h0019
`define FCQ_D_TYP_WR 16'h0003
`define FCQ_D_TYP_BLK 16'h0009
`define FCQ_D_MAX_WR 16'h0005
`define FCQ_D_MAX_BLK 16'h0004
`define FCQ_D_SIZE 16'h0014
`define FCQ_D_IFACE 16'h0002
`define FCQ_D_NREG 16'h0002
`define FCQ_D_R1_CNT 16'h0007
`define FCQ_D_R1_SZ 16'h0020
`define FCQ_D_R2_CNT 16'h000e
`define FCQ_D_R2_SZH 16'h0001
`define FCQ_D_NONE 16'h0000
`define FCQ_LOW_BYTE 16'h00ff

`define FCQ_CLK_NS 10
`define FCQ_T_SETUP_NS 30
`define FCQ_T_WP_NS 60
`define FCQ_T_HOLD_NS 30
`define FCQ_T_ACC_NS 120
`define FCQ_T_GAP_NS 30
`define FCQ_SYNC_CYC 2
`define FCQ_CYC(ns) ((ns + `FCQ_CLK_NS - 1) / `FCQ_CLK_NS)

`endif

// File: include/fcq_pkg.sv
// Types shared by the query-table reader.
package fcq_pkg;

    typedef enum logic [2:0] {
        FCQ_IDLE = 3'h0,
        FCQ_W_SET = 3'h1,
        FCQ_W_LOW = 3'h3,
        FCQ_W_HIGH = 3'h2,
        FCQ_R_LOW = 3'h6,
        FCQ_R_SMP = 3'h7,
        FCQ_R_GAP = 3'h5,
        FCQ_FIN = 3'h4
    } fcq_state_e;

    typedef logic [15:0] fcq_word_t;
    typedef logic [5:0] fcq_idx_t;
    typedef logic [7:0] fcq_cnt_t;

endpackage : fcq_pkg

// File: hdl/fcq_table_mem.sv
// Small memory holding the query words read back from the flash.
`timescale 1ns/100ps
module fcq_table_mem
    import fcq_pkg::*;
(
    input wire logic core_clk,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire fcq_idx_t wr_idx,
    input wire fcq_word_t wr_data,
    input wire fcq_idx_t rd_idx,
    output fcq_word_t rd_data
);
    fcq_word_t mem [0:63];

    always_ff @(posedge core_clk) begin
        if (clk_en && wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // The read port is registered, so the data lag the index by one enabled edge.
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            rd_data <= mem[rd_idx];
        end
    end
endmodule : fcq_table_mem

// File: hdl/fcq_query_host.sv
// Host controller that enters query mode, reads and checks the query table, then leaves.
// Function
// RULE1 - Write 98h to 55h/AAh enters query.
// RULE2 - Word mode reads keep A7 upward zero.
// RULE3 - Reset command ends query reading.
// RULE4 - Query from identification; reset returns there.
// RULE5 - Words 10h-12h read 0051h 0052h 0059h.
// RULE6 - Command set 0002h at 13h, 0000h 14h.
// RULE7 - Extended table pointer 0040h at 15h.
// RULE8 - Words 17h through 1Ah read zero.
// RULE9 - Supply codes 0017h at 1Bh, 0019h 1Ch.
// RULE10 - Words 1Dh and 1Eh read zero.
// RULE11 - Typical timeouts 0003h at 1Fh, 0009h 21h.
// RULE12 - Max multipliers 0005h at 23h, 0004h 25h.
// RULE13 - Word 27h reads size code 0014h.
// RULE14 - Interface code 0002h at 28h.
// RULE15 - Words 2Ah and 2Bh read zero.
// RULE16 - Word 2Ch reads region count 0002h.
// RULE17 - Region one 0007h 0000h 0020h 0000h.
// RULE18 - Region two 000Eh 0000h 0000h 0001h.
// RULE19 - Regions three and four read zero.
// RULE20 - Reset returns array read, address ignored.
// RULE21 - Byte mode doubles address, low byte only.
// RULE22 - Reads persist in query until reset.
`timescale 1ns/100ps
`include "fcq_consts.svh"
module fcq_query_host
    import fcq_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic start,
    input wire logic byte_mode,
    input wire logic from_ident,
    input wire fcq_idx_t rd_idx,
    output fcq_word_t rd_data,
    output logic busy_reg,
    output logic done_reg,
    output logic mismatch_reg,
    output logic ident_mode_reg,
    output logic ce_n_reg,
    output logic we_n_reg,
    output logic oe_n_reg,
    output logic byte_n_reg,
    output logic [19:0] addr_reg,
    input wire fcq_word_t dq_in,
    output fcq_word_t dq_out_reg,
    output logic dq_oe_reg
);
    localparam fcq_cnt_t C_SETUP = fcq_cnt_t'(`FCQ_CYC(`FCQ_T_SETUP_NS));
    localparam fcq_cnt_t C_WP = fcq_cnt_t'(`FCQ_CYC(`FCQ_T_WP_NS));
    localparam fcq_cnt_t C_HOLD = fcq_cnt_t'(`FCQ_CYC(`FCQ_T_HOLD_NS));
    localparam fcq_cnt_t C_ACC = fcq_cnt_t'(`FCQ_CYC(`FCQ_T_ACC_NS) + `FCQ_SYNC_CYC);
    localparam fcq_cnt_t C_GAP = fcq_cnt_t'(`FCQ_CYC(`FCQ_T_GAP_NS));

    logic rst_meta_reg;
    logic rst_sync_reg;
    fcq_word_t dq_meta_reg;
    fcq_word_t dq_sync_reg;
    fcq_state_e state_reg;
    fcq_cnt_t cnt_reg;
    fcq_idx_t idx_reg;
    logic rst_phase_reg;
    logic byte_reg;
    logic cnt_done;
    logic last_idx;
    fcq_word_t got_word;
    fcq_word_t exp_word;
    logic mem_wr;

    // Expected query word for a table index; absent entries are zero.
    function automatic fcq_word_t fcq_expect(input fcq_idx_t idx);
        fcq_word_t w;
        w = `FCQ_D_NONE;
        unique case (idx)
            // RULE5 query identifier
            `FCQ_A_Q: w = `FCQ_D_Q;
            `FCQ_A_R: w = `FCQ_D_R;
            `FCQ_A_Y: w = `FCQ_D_Y;
            // RULE6 command set
            `FCQ_A_PRI_SET: w = `FCQ_D_PRI_SET;
            // RULE7 extended pointer
            `FCQ_A_PRI_TBL: w = `FCQ_D_PRI_TBL;
            // RULE9 supply range
            `FCQ_A_VCC_MIN: w = `FCQ_D_VCC_MIN;
            `FCQ_A_VCC_MAX: w = `FCQ_D_VCC_MAX;
            // RULE11 typical timeouts
            `FCQ_A_TYP_WR: w = `FCQ_D_TYP_WR;
            `FCQ_A_TYP_BLK: w = `FCQ_D_TYP_BLK;
            // RULE12 maximum multipliers
            `FCQ_A_MAX_WR: w = `FCQ_D_MAX_WR;
            `FCQ_A_MAX_BLK: w = `FCQ_D_MAX_BLK;
            // RULE13 device size
            `FCQ_A_SIZE: w = `FCQ_D_SIZE;
            // RULE14 interface code
            `FCQ_A_IFACE: w = `FCQ_D_IFACE;
            // RULE16 region count
            `FCQ_A_NREG: w = `FCQ_D_NREG;
            // RULE17 first region
            `FCQ_A_R1_CNT: w = `FCQ_D_R1_CNT;
            `FCQ_A_R1_SZ: w = `FCQ_D_R1_SZ;
            // RULE18 second region
            `FCQ_A_R2_CNT: w = `FCQ_D_R2_CNT;
            `FCQ_A_R2_SZH: w = `FCQ_D_R2_SZH;
            // RULE8 RULE10 RULE15 RULE19 zero entries
            default: w = `FCQ_D_NONE;
        endcase
        return w;
    endfunction : fcq_expect

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // The data pins come from the flash, outside this clock's timing, so they pass two stages.
    always_ff @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            dq_meta_reg <= `FCQ_D_NONE;
            dq_sync_reg <= `FCQ_D_NONE;
        end else if (clk_en) begin
            dq_meta_reg <= dq_in;
            dq_sync_reg <= dq_meta_reg;
        end
    end

    assign cnt_done = (cnt_reg == fcq_cnt_t'(0));
    assign last_idx = (idx_reg == `FCQ_IDX_LAST);
    // RULE21 low byte only
    assign got_word = byte_reg ? (dq_sync_reg & `FCQ_LOW_BYTE) : dq_sync_reg;
    assign exp_word = fcq_expect(idx_reg);
    assign mem_wr = clk_en && (state_reg == FCQ_R_SMP) && cnt_done;

    always_ff @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg <= FCQ_IDLE;
            cnt_reg <= fcq_cnt_t'(0);
            idx_reg <= `FCQ_IDX_ZERO;
            rst_phase_reg <= 1'b0;
            byte_reg <= 1'b0;
        end else if (clk_en) begin
            unique case (state_reg)
                FCQ_IDLE: begin
                    if (start) begin
                        state_reg <= FCQ_W_SET;
                        cnt_reg <= C_SETUP - fcq_cnt_t'(1);
                        rst_phase_reg <= 1'b0;
                        byte_reg <= byte_mode;
                        idx_reg <= `FCQ_IDX_FIRST;
                    end
                end
                FCQ_W_SET: begin
                    if (cnt_done) begin
                        state_reg <= FCQ_W_LOW;
                        cnt_reg <= C_WP - fcq_cnt_t'(1);
                    end else begin
                        cnt_reg <= cnt_reg - fcq_cnt_t'(1);
                    end
                end
                FCQ_W_LOW: begin
                    if (cnt_done) begin
                        state_reg <= FCQ_W_HIGH;
                        cnt_reg <= C_HOLD - fcq_cnt_t'(1);
                    end else begin
                        cnt_reg <= cnt_reg - fcq_cnt_t'(1);
                    end
                end
                FCQ_W_HIGH: begin
                    if (!cnt_done) begin
                        cnt_reg <= cnt_reg - fcq_cnt_t'(1);
                    end else if (rst_phase_reg) begin
                        state_reg <= FCQ_FIN;
                    end else begin
                        // RULE22 reads repeat while in query
                        state_reg <= FCQ_R_LOW;
                        cnt_reg <= C_ACC - fcq_cnt_t'(1);
                    end
                end
                FCQ_R_LOW: begin
                    if (cnt_done) begin
                        state_reg <= FCQ_R_SMP;
                    end else begin
                        cnt_reg <= cnt_reg - fcq_cnt_t'(1);
                    end
                end
                FCQ_R_SMP: begin
                    state_reg <= FCQ_R_GAP;
                    cnt_reg <= C_GAP - fcq_cnt_t'(1);
                end
                FCQ_R_GAP: begin
                    if (!cnt_done) begin
                        cnt_reg <= cnt_reg - fcq_cnt_t'(1);
                    end else if (last_idx) begin
                        // RULE3 issue reset command
                        state_reg <= FCQ_W_SET;
                        cnt_reg <= C_SETUP - fcq_cnt_t'(1);
                        rst_phase_reg <= 1'b1;
                    end else begin
                        state_reg <= FCQ_R_LOW;
                        cnt_reg <= C_ACC - fcq_cnt_t'(1);
                        idx_reg <= idx_reg + fcq_idx_t'(1);
                    end
                end
                FCQ_FIN: begin
                    state_reg <= FCQ_IDLE;
                end
            endcase
        end
    end

    // Pin drive follows the state; strobes are registered so they never glitch.
    always_ff @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            ce_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            dq_oe_reg <= 1'b0;
            dq_out_reg <= `FCQ_D_NONE;
            addr_reg <= `FCQ_RST_ADDR;
            byte_n_reg <= 1'b1;
        end else if (clk_en) begin
            byte_n_reg <= !byte_reg;
            unique case (state_reg)
                FCQ_W_SET: begin
                    ce_n_reg <= 1'b0;
                    oe_n_reg <= 1'b1;
                    dq_oe_reg <= 1'b1;
                    if (rst_phase_reg) begin
                        // RULE20 reset address ignored
                        addr_reg <= `FCQ_RST_ADDR;
                        dq_out_reg <= {8'h00, `FCQ_CMD_RESET};
                    end else begin
                        // RULE1 query command address
                        addr_reg <= byte_reg ? `FCQ_QADDR_BYTE : `FCQ_QADDR_WORD;
                        dq_out_reg <= {8'h00, `FCQ_CMD_QUERY};
                    end
                    we_n_reg <= !(cnt_done);
                end
                FCQ_W_LOW: begin
                    we_n_reg <= cnt_done;
                end
                FCQ_W_HIGH: begin
                    we_n_reg <= 1'b1;
                    ce_n_reg <= cnt_done;
                    dq_oe_reg <= !cnt_done;
                end
                FCQ_R_LOW: begin
                    // RULE2 upper bits zero, RULE21 doubled address
                    addr_reg <= byte_reg ? {13'h0000, idx_reg, 1'b0} : {14'h0000, idx_reg};
                    ce_n_reg <= 1'b0;
                    oe_n_reg <= 1'b0;
                end
                FCQ_R_SMP: begin
                    ce_n_reg <= 1'b1;
                    oe_n_reg <= 1'b1;
                end
                FCQ_R_GAP, FCQ_IDLE, FCQ_FIN: begin
                    ce_n_reg <= 1'b1;
                    oe_n_reg <= 1'b1;
                    we_n_reg <= 1'b1;
                    dq_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // Status for the user side.
    always_ff @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            mismatch_reg <= 1'b0;
            ident_mode_reg <= 1'b0;
        end else if (clk_en) begin
            done_reg <= (state_reg == FCQ_FIN);
            busy_reg <= (state_reg != FCQ_IDLE) || start;
            if (state_reg == FCQ_IDLE && start) begin
                mismatch_reg <= 1'b0;
                // RULE4 exit returns to identification
                ident_mode_reg <= from_ident;
            end else if (mem_wr && got_word != exp_word) begin
                mismatch_reg <= 1'b1;
            end
        end
    end

    fcq_table_mem u_mem (
        .core_clk(core_clk),
        .clk_en(clk_en),
        .wr_en(mem_wr),
        .wr_idx(idx_reg),
        .wr_data(got_word),
        .rd_idx(rd_idx),
        .rd_data(rd_data)
    );
endmodule : fcq_query_host

// File: sim/fcq_query_host_asserts.sv
// Checker of the query host's flash strobes and status outputs.
`timescale 1ns/100ps
`include "fcq_consts.svh"
module fcq_query_host_asserts
    import fcq_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic start,
    input wire logic byte_mode,
    input wire logic from_ident,
    input wire fcq_idx_t rd_idx,
    input wire fcq_word_t rd_data,
    input wire logic busy_reg,
    input wire logic done_reg,
    input wire logic mismatch_reg,
    input wire logic ident_mode_reg,
    input wire logic ce_n_reg,
    input wire logic we_n_reg,
    input wire logic oe_n_reg,
    input wire logic byte_n_reg,
    input wire logic [19:0] addr_reg,
    input wire fcq_word_t dq_in,
    input wire fcq_word_t dq_out_reg,
    input wire logic dq_oe_reg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    chk_write_frame: assert property (
        !we_n_reg |-> !ce_n_reg && oe_n_reg && dq_oe_reg) else $error("bad write frame");
    chk_query_addr: assert property (
        $fell(we_n_reg) && dq_out_reg[7:0] == `FCQ_CMD_QUERY
        |-> addr_reg == (byte_n_reg ? `FCQ_QADDR_WORD : `FCQ_QADDR_BYTE))
        else $error("query command at wrong address");
    chk_word_high: assert property (
        !oe_n_reg && byte_n_reg |-> addr_reg[19:7] == 13'h0000) else $error("upper address set");
    chk_byte_even: assert property (
        !oe_n_reg && !byte_n_reg |-> !addr_reg[0]) else $error("odd byte address");
    chk_read_frame: assert property (
        !oe_n_reg |-> !ce_n_reg && we_n_reg && !dq_oe_reg) else $error("bad read frame");
    chk_reset_done: assert property (
        $rose(we_n_reg) && dq_out_reg[7:0] == `FCQ_CMD_RESET |-> ##[1:20] done_reg)
        else $error("no done after reset command");
    chk_done_idle: assert property (
        done_reg |-> ce_n_reg && we_n_reg && oe_n_reg && !dq_oe_reg ##1 !done_reg)
        else $error("done while strobing");
    chk_ident_take: assert property (
        start && !busy_reg && clk_en |=> busy_reg && ident_mode_reg == $past(from_ident))
        else $error("start not taken");
    cov_word: cover property (done_reg && byte_n_reg);
    cov_byte: cover property (done_reg && !byte_n_reg && ident_mode_reg);
    cov_bad: cover property (done_reg && mismatch_reg);
endmodule : fcq_query_host_asserts

bind fcq_query_host fcq_query_host_asserts u_chk (.core_clk, .arst_n, .clk_en, .start,
    .byte_mode, .from_ident, .rd_idx, .rd_data, .busy_reg, .done_reg, .mismatch_reg,
    .ident_mode_reg, .ce_n_reg, .we_n_reg, .oe_n_reg, .byte_n_reg, .addr_reg, .dq_in,
    .dq_out_reg, .dq_oe_reg);

// File: sim/fcq_flash_model.sv
// Behavioural flash that answers query-mode entry, table reads and reset.
`timescale 1ns/100ps
`include "fcq_consts.svh"
module fcq_flash_model
    import fcq_pkg::*;
(
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic byte_n,
    input wire logic [19:0] addr,
    input wire fcq_word_t dq_wr,
    input wire logic set_ident,
    input wire logic slow,
    input wire fcq_idx_t bad_idx,
    output fcq_word_t dq_rd,
    output logic [1:0] mode
);
    logic back_ident = 1'b0;
    fcq_idx_t idx;
    fcq_word_t w;
    function automatic fcq_word_t tbl(input fcq_idx_t i);
        case (i)
            `FCQ_A_Q: return `FCQ_D_Q;
            `FCQ_A_R: return `FCQ_D_R;
            `FCQ_A_Y: return `FCQ_D_Y;
            `FCQ_A_PRI_SET: return `FCQ_D_PRI_SET;
            `FCQ_A_PRI_TBL: return `FCQ_D_PRI_TBL;
            `FCQ_A_VCC_MIN: return `FCQ_D_VCC_MIN;
            `FCQ_A_VCC_MAX: return `FCQ_D_VCC_MAX;
            `FCQ_A_TYP_WR: return `FCQ_D_TYP_WR;
            `FCQ_A_TYP_BLK: return `FCQ_D_TYP_BLK;
            `FCQ_A_MAX_WR: return `FCQ_D_MAX_WR;
            `FCQ_A_MAX_BLK: return `FCQ_D_MAX_BLK;
            `FCQ_A_SIZE: return `FCQ_D_SIZE;
            `FCQ_A_IFACE: return `FCQ_D_IFACE;
            `FCQ_A_NREG: return `FCQ_D_NREG;
            `FCQ_A_R1_CNT: return `FCQ_D_R1_CNT;
            `FCQ_A_R1_SZ: return `FCQ_D_R1_SZ;
            `FCQ_A_R2_CNT: return `FCQ_D_R2_CNT;
            `FCQ_A_R2_SZH: return `FCQ_D_R2_SZH;
            default: return `FCQ_D_NONE;
        endcase
    endfunction : tbl
    initial mode = 2'h0;
    always @(posedge set_ident) mode = 2'h1;
    always @(posedge we_n) begin
        if (!ce_n && dq_wr[7:0] == `FCQ_CMD_QUERY && mode != 2'h2
            && addr == (byte_n ? `FCQ_QADDR_WORD : `FCQ_QADDR_BYTE)) begin
            back_ident = (mode == 2'h1);
            mode = 2'h2;
        end else if (!ce_n && dq_wr[7:0] == `FCQ_CMD_RESET) begin
            mode = (mode == 2'h2 && back_ident) ? 2'h1 : 2'h0;
        end
    end
    // answer after access time; lines churn outside it.
    initial dq_rd = 16'h3c3c;
    always begin
        @(negedge oe_n);
        dq_rd = ~dq_rd;
        #(slow ? 100 : 40);
        idx = byte_n ? addr[5:0] : addr[6:1];
        w = tbl(idx) ^ {15'h0000, idx == bad_idx};
        if (mode != 2'h2) dq_rd = 16'hbeef;
        else dq_rd = byte_n ? w : {8'ha5, w[7:0]};
        @(posedge oe_n);
        dq_rd = ~dq_rd;
    end
endmodule : fcq_flash_model

// File: sim/fcq_query_host_bench.sv
// Self-checking bench for the query host against the flash model.
`timescale 1ns/100ps
module fcq_query_host_bench
    import fcq_pkg::*;
;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic start = 1'b0;
    logic byte_mode = 1'b0;
    logic from_ident = 1'b0;
    logic set_ident = 1'b0;
    logic slow = 1'b0;
    fcq_idx_t rd_idx = 6'h00;
    fcq_idx_t bad_idx = 6'h00;
    fcq_word_t rd_data, dq_in, dq_out_reg, dq_rd;
    logic busy_reg, done_reg, mismatch_reg, ident_mode_reg, ce_n_reg, we_n_reg, oe_n_reg;
    logic byte_n_reg, dq_oe_reg;
    logic [19:0] addr_reg;
    logic [1:0] mode, mid_mode;
    logic mid_busy;
    int fail_count = 0;
    int checks_done = 0;
    int dones = 0;
    always #5 core_clk = ~core_clk;
    // The host owns the data lines while its enable is high.
    assign dq_in = dq_oe_reg ? dq_out_reg : dq_rd;
    always @(posedge core_clk) if (done_reg) dones <= dones + 1;
    fcq_query_host dut (.core_clk, .arst_n, .clk_en, .start, .byte_mode, .from_ident, .rd_idx,
        .rd_data, .busy_reg, .done_reg, .mismatch_reg, .ident_mode_reg, .ce_n_reg, .we_n_reg,
        .oe_n_reg, .byte_n_reg, .addr_reg, .dq_in, .dq_out_reg, .dq_oe_reg);
    fcq_flash_model flash (.ce_n(ce_n_reg), .we_n(we_n_reg), .oe_n(oe_n_reg),
        .byte_n(byte_n_reg), .addr(addr_reg), .dq_wr(dq_in), .set_ident, .slow, .bad_idx,
        .dq_rd, .mode);
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    // A second start inside the run must be ignored; clk_en may pause the run.
    task automatic run(input logic b, input logic fi, input int poke, input int pause);
        int n = 0;
        byte_mode = b;
        from_ident = fi;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        while (done_reg !== 1'b1 && n < 3000) begin
            start = (n == poke);
            clk_en = !(n >= pause && n < pause + 20);
            if (n == 60) begin
                mid_mode = mode;
                mid_busy = busy_reg;
            end
            tick(1);
            n++;
        end
        if (n == 3000) begin
            fail_count++;
            wrap_up();
        end
        tick(2);
    endtask : run
    task automatic readback(input logic [15:0] msk);
        for (int i = 16; i <= 60; i++) begin
            rd_idx = 6'(i);
            tick(2);
            check(20'(rd_data), 20'(flash.tbl(6'(i)) & msk));
        end
    endtask : readback
    // The pins must rest idle and the status low while the run has not begun.
    task automatic t_reset_idle();
        check(20'({ce_n_reg, we_n_reg, oe_n_reg, dq_oe_reg}), 20'he);
        check(20'({busy_reg, done_reg, byte_n_reg}), 20'h1);
        check(addr_reg, 20'h00000);
        $display("reset idle test ended");
    endtask : t_reset_idle
    task automatic t_word_array();
        run(1'b0, 1'b0, 100, -100);
        check(20'(mid_mode), 20'h2);
        check(20'(dones), 20'h1);
        check(20'(busy_reg), 20'h0);
        check(20'(mid_busy), 20'h1);
        check(20'(mode), 20'h0);
        check(20'(mismatch_reg), 20'h0);
        readback(16'hffff);
        $display("word array test ended");
    endtask : t_word_array
    task automatic t_bad_entry();
        bad_idx = 6'h27;
        run(1'b0, 1'b0, -1, -100);
        check(20'(mismatch_reg), 20'h1);
        bad_idx = 6'h00;
        $display("bad entry test ended");
    endtask : t_bad_entry
    task automatic t_byte_ident();
        set_ident = 1'b1;
        tick(1);
        set_ident = 1'b0;
        slow = 1'b1;
        run(1'b1, 1'b1, -1, 60);
        check(20'(mid_mode), 20'h2);
        check(20'(mode), 20'h1);
        check(20'(ident_mode_reg), 20'h1);
        check(20'(byte_n_reg), 20'h0);
        check(20'(mismatch_reg), 20'h0);
        readback(16'h00ff);
        $display("byte ident test ended");
    endtask : t_byte_ident
    initial begin
        tick(20);
        arst_n = 1'b1;
        tick(5);
        t_reset_idle();
        t_word_array();
        t_bad_entry();
        t_byte_ident();
        wrap_up();
    end
endmodule : fcq_query_host_bench
